// [hdl/dpf_top.sv]
/*
  Drive protection and input filter: factory restore sequence, overload,
  lock-rotor, overheat and torque shortfall faults, encoder and terminal
  filters, APB register file and interrupt.
  Assumes all inputs synchronous to the 10 MHz clk and an APB master.
*/
`timescale 1ns/1ns
module dpf_top #(
  parameter int TICK_CYCLES    = dpf_pkg::TICK_CYC,
  parameter int DI_TICK_CYCLES = dpf_pkg::DI_TICK_CYC,
  parameter int OVL_UNIT       = 100,
  parameter int LOCK_SPEED     = 10,
  parameter int LOCK_CURRENT   = 200
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  // APB slave
  input  wire logic [7:0]         paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Motor, keypad and terminals
  input  wire dpf_pkg::dpf_motor_s motor,
  input  wire logic               setKey,
  input  wire logic [2:0]         encIn,
  input  wire logic [7:0]         digitalInputTerminals,
  // Filtered levels
  output logic [2:0]              encOut,
  output logic [7:0]              diOut,
  // Faults and status
  output dpf_pkg::dpf_fault_s     faults,
  output logic [7:0]              faultCode,
  output logic                    displayZeros,
  output logic                    defaultsLoaded,
  output logic                    irq
);
  import dpf_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES);
  localparam int DW = $clog2(DI_TICK_CYCLES);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    dpf_cfg_s     cfg;
    logic         restoreAct;
    logic [TW-1:0] tickCnt;
    logic [DW-1:0] diCnt;
    logic [31:0]  heat;
    dpf_fault_s   faults;
    logic [7:0]   code;
    dpf_restore_e rs;
    logic [9:0]   rsCnt;
    logic         zeros;
    logic         loaded;
    logic [4:0]   irqSt;
    logic [4:0]   irqMask;
    logic         irq;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
  } dpf_top_s;

  localparam dpf_top_s ST_RESET = '{cfg: CFG_DEFAULT, rs: RS_IDLE, default: '0};

  dpf_top_s q, d;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic inRange(logic [31:0] v, logic [31:0] lo, logic [31:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  // Encoder window in clocks, rounded up so no short level survives
  function automatic logic [9:0] encCycles(logic [9:0] c);
    return 10'((int'(c) * CLK_MHZ + ENC_REF_MHZ - 1) / ENC_REF_MHZ);
  endfunction

  // Highest priority latched fault names the code
  function automatic logic [7:0] codeOf(dpf_fault_s f);
    if (f.overheat) return FC_OVH;
    if (f.overload) return FC_OVL;
    if (f.lockRotor) return FC_LOCK;
    if (f.torqueShort) return FC_TQ;
    return FC_NONE;
  endfunction

  // ----------------------------------------
  // Ticks and filters
  // ----------------------------------------
  logic        tick;
  logic        diTick;
  logic [7:0]  diLvl;
  logic [2:0]  encLvl;
  logic [15:0] speedMag;
  logic        lockCond;
  logic        tqCond;
  logic        lockTrip;
  logic        tqTrip;

  assign tick   = (q.tickCnt == TW'(TICK_CYCLES - 1));
  assign diTick = (q.diCnt == DW'(DI_TICK_CYCLES - 1));

  // Each terminal has its own window
  for (genvar i = 0; i < 8; i++) begin : g_di
    dpf_glitch_filter #(.W(15)) u_di (
      .clk  (clk),
      .rst  (rst),
      .ce   (diTick),
      .len  (q.cfg.diTime[i]),                       // RQ11
      .din  (digitalInputTerminals[i]),
      .dout (diLvl[i])
    );
  end

  // Encoder lines sampled every clock
  for (genvar i = 0; i < 3; i++) begin : g_enc
    dpf_glitch_filter #(.W(10)) u_enc (
      .clk  (clk),
      .rst  (rst),
      .ce   (1'b1),
      .len  (encCycles(q.cfg.encCoef)),              // RQ8
      .din  (encIn[i]),
      .dout (encLvl[i])
    );
  end

  // Lock rotor: stalled shaft drawing very high current
  assign speedMag = motor.speed[15] ? 16'(-motor.speed) : 16'(motor.speed);
  assign lockCond = q.cfg.lockEn && (speedMag <= 16'(LOCK_SPEED))
                    && (motor.current >= 16'(LOCK_CURRENT));   // RQ5
  assign tqCond   = q.cfg.tqEn && (motor.outTorque < motor.cmdTorque);  // RQ9

  dpf_persist_timer #(.W(10)) u_lock (
    .clk   (clk),
    .rst   (rst),
    .ce    (tick),
    .cond  (lockCond),
    .limit (q.cfg.lockDly),                          // RQ6
    .trip  (lockTrip)
  );

  dpf_persist_timer #(.W(7)) u_tq (
    .clk   (clk),
    .rst   (rst),
    .ce    (tick),
    .cond  (tqCond),
    .limit (q.cfg.tqTime),                           // RQ10
    .trip  (tqTrip)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic [31:0] rd;
  logic        ok;
  logic        done;
  logic        restart;
  logic [31:0] ovlLimit;
  logic        ovlTrip;
  logic [4:0]  ev;
  logic [2:0]  di;

  // Register read data and access check, decoded from the held address
  always_comb begin
    rd = '0;
    ok = (paddr[1:0] == 2'b00);
    di = paddr[4:2];
    unique case (paddr)
      OFS_RESTORE: begin
        rd = 32'(q.cfg.restore);
        ok = ok && (!pwrite || inRange(pwdata, '0, MAX_FLAG));   // RQ2
      end
      OFS_RESTART: rd = '0;
      OFS_OVLCOEF: begin
        rd = 32'(q.cfg.ovlCoef);
        ok = ok && (!pwrite || inRange(pwdata, '0, MAX_OVL));
      end
      OFS_LOCKEN: begin
        rd = 32'(q.cfg.lockEn);
        ok = ok && (!pwrite || inRange(pwdata, '0, MAX_FLAG));
      end
      OFS_LOCKDLY: begin
        rd = 32'(q.cfg.lockDly);
        ok = ok && (!pwrite || inRange(pwdata, MIN_LOCKDLY, MAX_LOCKDLY));
      end
      OFS_OVHEN: begin
        rd = 32'(q.cfg.ovhEn);
        ok = ok && (!pwrite || inRange(pwdata, '0, MAX_FLAG));
      end
      OFS_ENCCOEF: begin
        rd = 32'(q.cfg.encCoef);
        ok = ok && (!pwrite || inRange(pwdata, '0, MAX_ENC));
      end
      OFS_TQEN: begin
        rd = 32'(q.cfg.tqEn);
        ok = ok && (!pwrite || inRange(pwdata, '0, MAX_FLAG));
      end
      OFS_TQTIME: begin
        rd = 32'(q.cfg.tqTime);
        ok = ok && (!pwrite || inRange(pwdata, MIN_TQTIME, MAX_TQTIME));
      end
      OFS_FAULT: begin
        rd = {14'h0, q.zeros, q.restoreAct, q.code, 4'h0, q.faults};
        ok = ok && !pwrite;
      end
      OFS_IRQST: begin
        rd = 32'(q.irqSt);
        ok = ok && !pwrite;
      end
      OFS_IRQMASK: rd = 32'(q.irqMask);
      OFS_INPUTS: begin
        rd = {21'h0, encLvl, diLvl};
        ok = ok && !pwrite;
      end
      default: begin
        if (paddr[7:5] == OFS_DITIME[7:5]) begin
          rd = 32'(q.cfg.diTime[di]);
          ok = ok && (!pwrite || inRange(pwdata, '0, MAX_DITIME));
        end else begin
          ok = 1'b0;                                 // unmapped
        end
      end
    endcase
  end

  assign done    = psel && penable && q.pready;
  assign restart = done && pwrite && !q.pslverr && (paddr == OFS_RESTART) && pwdata[0];
  // Coefficient stretches or shrinks the allowed heat store
  assign ovlLimit = 32'(q.cfg.ovlCoef) * 32'(OVL_UNIT);                  // RQ4
  assign ovlTrip  = (q.heat > ovlLimit) && (motor.current > RATED_PCT);  // RQ3

  always_comb begin
    d = q;
    d.loaded  = 1'b0;
    ev        = '0;
    d.tickCnt = tick ? '0 : q.tickCnt + 1'b1;
    d.diCnt   = diTick ? '0 : q.diCnt + 1'b1;

    // Heat store: excess over rated current adds, shortfall drains
    if (tick) begin
      if (motor.current > RATED_PCT) begin
        d.heat = q.heat + 32'(motor.current - RATED_PCT);               // RQ3
      end else if (q.heat > 32'(RATED_PCT - motor.current)) begin
        d.heat = q.heat - 32'(RATED_PCT - motor.current);
      end else begin
        d.heat = '0;
      end
    end

    // New fault events only where the fault is not already latched
    ev[0] = ovlTrip && !q.faults.overload;
    ev[1] = lockTrip && !q.faults.lockRotor;
    ev[2] = q.cfg.ovhEn && motor.overheat && !q.faults.overheat;         // RQ7
    ev[3] = tqTrip && !q.faults.torqueShort;

    // Restart clears latched faults; an event in the same cycle still lands
    if (restart) begin
      d.faults     = '0;
      d.heat       = '0;
      d.restoreAct = q.cfg.restore;                  // RQ2
    end
    d.faults.overload    = d.faults.overload | ev[0];                    // RQ13
    d.faults.lockRotor   = d.faults.lockRotor | ev[1];                   // RQ13
    d.faults.overheat    = d.faults.overheat | ev[2];                    // RQ13
    d.faults.torqueShort = d.faults.torqueShort | ev[3];                 // RQ13
    d.code = codeOf(d.faults);                                           // RQ13

    // Factory restore sequence
    unique case (q.rs)
      RS_IDLE: begin
        d.rsCnt = '0;
        if (q.restoreAct && setKey) begin
          d.rs = RS_HOLD;
        end
      end
      RS_HOLD: begin
        if (!setKey) begin
          d.rs = RS_IDLE;
        end else if (tick) begin
          // One extra tick absorbs the partial first tick
          if (q.rsCnt == HOLD_TICKS) begin
            d.rs    = RS_SHOW;
            d.rsCnt = '0;
            d.zeros = 1'b1;                          // RQ1
          end else begin
            d.rsCnt = q.rsCnt + 1'b1;
          end
        end
      end
      RS_SHOW: begin
        if (tick) begin
          if (q.rsCnt == WAIT_TICKS) begin
            d.rs         = RS_IDLE;
            d.zeros      = 1'b0;
            d.cfg        = CFG_DEFAULT;              // RQ1
            d.restoreAct = 1'b0;
            d.loaded     = 1'b1;
            ev[4]        = 1'b1;
          end else begin
            d.rsCnt = q.rsCnt + 1'b1;
          end
        end
      end
    endcase

    // APB: one wait state, then the completing edge applies the access
    d.pready  = psel && penable && !q.pready;
    d.prdata  = rd;
    d.pslverr = !ok;
    if (done && pwrite && !q.pslverr && !d.loaded) begin
      unique case (paddr)
        OFS_RESTORE: d.cfg.restore = pwdata[0];      // RQ2
        OFS_OVLCOEF: d.cfg.ovlCoef = pwdata[8:0];    // RQ4
        OFS_LOCKEN:  d.cfg.lockEn  = pwdata[0];      // RQ5
        OFS_LOCKDLY: d.cfg.lockDly = pwdata[9:0];    // RQ6
        OFS_OVHEN:   d.cfg.ovhEn   = pwdata[0];      // RQ7
        OFS_ENCCOEF: d.cfg.encCoef = pwdata[9:0];    // RQ8
        OFS_TQEN:    d.cfg.tqEn    = pwdata[0];      // RQ9
        OFS_TQTIME:  d.cfg.tqTime  = pwdata[6:0];    // RQ10
        OFS_IRQMASK: d.irqMask     = pwdata[4:0];
        default: begin
          if (paddr[7:5] == OFS_DITIME[7:5]) begin
            d.cfg.diTime[di] = pwdata[14:0];         // RQ11
          end
        end
      endcase
    end

    // Read clears only the bits that were reported, so new events survive
    if (done && !pwrite && paddr == OFS_IRQST) begin
      d.irqSt = q.irqSt & ~q.prdata[4:0];
    end
    d.irqSt = d.irqSt | ev;
    d.irq   = |(d.irqSt & d.irqMask);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= ST_RESET;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata         = q.prdata;
  assign pready         = q.pready;
  assign pslverr        = q.pslverr;
  assign encOut         = encLvl;
  assign diOut          = diLvl;
  assign faults         = q.faults;
  assign faultCode      = q.code;
  assign displayZeros   = q.zeros;
  assign defaultsLoaded = q.loaded;
  assign irq            = q.irq;

endmodule // dpf_top

// [hdl/dpf_pkg.sv]
/*
  Shared constants and types of the drive protection and input filter block:
  timing, register offsets, reset values, ranges, fault codes and carriers.
  Assumes a single 10 MHz drive clock.
*/
// Functional notes
// RQ1 - Restore armed and set key held 0.5 s: zeros shown, defaults loaded 5 s later.
// RQ2 - Restore setting takes 0 or 1, resets to 0, acts only after restart.
// RQ3 - Overload model: heat from current against released heat; trip on persistent excess.
// RQ4 - Overload coefficient 0..500 percent, default 100, scales time to overload trip.
// RQ5 - Lock-rotor enable, default 1: near-zero speed with very high current detected.
// RQ6 - Lock-rotor fault after condition lasts delay 10..1000 x 10 ms, default 50.
// RQ7 - Overheat protection enable, default 0, takes effect immediately.
// RQ8 - Nonzero encoder coefficient drops levels shorter than coefficient / 30 MHz.
// RQ9 - Torque shortfall enable, default 1: output torque below command is watched.
// RQ10 - Shortfall lasting 1..100 x 10 ms, default 10, trips torque shortfall fault.
// RQ11 - Eight input terminals filtered apart, each time 0..30000, default 2.
// RQ12 - New input level passes after stable for set sample ticks; zero passes straight.
// RQ13 - Faults latch until reset or restart and report their own fault code.
package dpf_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ      = 10_000_000;
  localparam int CLK_MHZ     = CLK_HZ / 1_000_000;
  localparam int TICK_MS     = 10;                          // protection timer unit
  localparam int TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
  localparam int DI_TICK_US  = 1000;                        // input filter sample period
  localparam int DI_TICK_CYC = CLK_MHZ * DI_TICK_US;
  localparam int HOLD_MS     = 500;                         // set key hold time
  localparam int WAIT_MS     = 5000;                        // zeros shown before reload
  localparam logic [9:0] HOLD_TICKS = 10'((HOLD_MS + TICK_MS - 1) / TICK_MS);
  localparam logic [9:0] WAIT_TICKS = 10'((WAIT_MS + TICK_MS - 1) / TICK_MS);
  localparam int ENC_REF_MHZ = 30;                          // encoder coefficient base

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_RESTORE  = 8'h00;
  localparam logic [7:0] OFS_RESTART  = 8'h04;
  localparam logic [7:0] OFS_OVLCOEF  = 8'h08;
  localparam logic [7:0] OFS_LOCKEN   = 8'h0c;
  localparam logic [7:0] OFS_LOCKDLY  = 8'h10;
  localparam logic [7:0] OFS_OVHEN    = 8'h14;
  localparam logic [7:0] OFS_ENCCOEF  = 8'h18;
  localparam logic [7:0] OFS_TQEN     = 8'h1c;
  localparam logic [7:0] OFS_TQTIME   = 8'h20;
  localparam logic [7:0] OFS_FAULT    = 8'h24;
  localparam logic [7:0] OFS_IRQST    = 8'h28;
  localparam logic [7:0] OFS_IRQMASK  = 8'h2c;
  localparam logic [7:0] OFS_INPUTS   = 8'h30;
  localparam logic [7:0] OFS_DITIME   = 8'h40;              // eight words up to 8'h5c

  // ----------------------------------------
  // Ranges and reset values
  // ----------------------------------------
  localparam logic [31:0] MAX_FLAG    = 32'h1;
  localparam logic [31:0] MAX_OVL     = 32'h1f4;            // 500 percent
  localparam logic [31:0] MIN_LOCKDLY = 32'ha;
  localparam logic [31:0] MAX_LOCKDLY = 32'h3e8;
  localparam logic [31:0] MAX_ENC     = 32'h3e8;
  localparam logic [31:0] MIN_TQTIME  = 32'h1;
  localparam logic [31:0] MAX_TQTIME  = 32'h64;
  localparam logic [31:0] MAX_DITIME  = 32'h7530;           // 30000
  localparam logic [15:0] RATED_PCT   = 16'h64;             // heat balance point

  // Fault codes, arbitrary values
  localparam logic [7:0] FC_NONE  = 8'h00;
  localparam logic [7:0] FC_OVH   = 8'h01;
  localparam logic [7:0] FC_OVL   = 8'h02;
  localparam logic [7:0] FC_LOCK  = 8'h03;
  localparam logic [7:0] FC_TQ    = 8'h04;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef logic [14:0] dpf_ditime_t;
  typedef enum logic [1:0] {RS_IDLE, RS_HOLD, RS_SHOW} dpf_restore_e;

  typedef struct packed {
    logic              restore;
    logic [8:0]        ovlCoef;
    logic              lockEn;
    logic [9:0]        lockDly;
    logic              ovhEn;
    logic [9:0]        encCoef;
    logic              tqEn;
    logic [6:0]        tqTime;
    dpf_ditime_t [7:0] diTime;
  } dpf_cfg_s;

  localparam dpf_cfg_s CFG_DEFAULT = '{restore: 1'b0, ovlCoef: 9'h64, lockEn: 1'b1,
    lockDly: 10'h32, ovhEn: 1'b0, encCoef: 10'h0, tqEn: 1'b1, tqTime: 7'ha,
    diTime: {8{15'h2}}};

  // Motor feedback; current and torques in percent of rated
  typedef struct packed {
    logic signed [15:0] speed;
    logic [15:0]        current;
    logic [15:0]        cmdTorque;
    logic [15:0]        outTorque;
    logic               overheat;
  } dpf_motor_s;

  typedef struct packed {
    logic overload;
    logic lockRotor;
    logic overheat;
    logic torqueShort;
  } dpf_fault_s;

endpackage

// [hdl/dpf_glitch_filter.sv]
/*
  One-bit level filter: a new level passes once it has been seen for len
  consecutive sample enables. Assumes din synchronous to clk.
*/
`timescale 1ns/1ns
module dpf_glitch_filter #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Sampling
  input  wire logic         ce,
  input  wire logic [W-1:0] len,
  input  wire logic         din,
  output logic              dout
);
  import dpf_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         out;
  } dpf_flt_s;

  dpf_flt_s q, d;

  // Count samples of a differing level; any return to the output level restarts
  always_comb begin
    d = q;
    if (len == '0) begin
      d.out = din;                                   // RQ12
      d.cnt = '0;
    end else if (din == q.out) begin
      d.cnt = '0;
    end else if (ce) begin
      if ({1'b0, q.cnt} + 1'b1 >= {1'b0, len}) begin
        d.out = din;                                 // RQ12
        d.cnt = '0;
      end else begin
        d.cnt = q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.out;

endmodule // dpf_glitch_filter

// [hdl/dpf_persist_timer.sv]
/*
  Persistence timer: one-cycle trip once cond has held for limit ticks,
  then silent until cond drops. Assumes ce is a one-cycle tick.
*/
`timescale 1ns/1ns
module dpf_persist_timer #(
  parameter int W = 10
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Condition and time
  input  wire logic         ce,
  input  wire logic         cond,
  input  wire logic [W-1:0] limit,
  output logic              trip
);
  import dpf_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         fired;
    logic         trip;
  } dpf_tmr_s;

  dpf_tmr_s q, d;

  // Fire once per unbroken run of the condition
  always_comb begin
    d = q;
    d.trip = 1'b0;
    if (!cond) begin
      d.cnt   = '0;
      d.fired = 1'b0;
    end else if (ce && !q.fired) begin
      if ({1'b0, q.cnt} + 1'b1 >= {1'b0, limit}) begin
        d.trip  = 1'b1;
        d.fired = 1'b1;
      end else begin
        d.cnt = q.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign trip = q.trip;

endmodule // dpf_persist_timer

// [testbench/dpf_properties.sv]
/* Checker for dpf_top port timing.
   Assumes one clock and rst async, active high. */
`timescale 1ns/1ns
module dpf_properties
  import dpf_pkg::*;
(
  // Clock, reset, bus
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [7:0] paddr,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pwrite,
  input wire logic       pready,
  // Inputs
  input wire dpf_pkg::dpf_motor_s motor,
  input wire logic       setKey,
  input wire logic [7:0] digitalInputTerminals,
  // Results
  input wire logic [7:0] diOut,
  input wire dpf_pkg::dpf_fault_s faults,
  input wire logic [7:0] faultCode,
  input wire logic       displayZeros,
  input wire logic       defaultsLoaded
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Restart landing, stall, shortfall, code by priority
  wire restartWr = psel && penable && pready && pwrite && paddr == OFS_RESTART;
  wire stall = motor.current >= 16'hc8 && motor.speed <= 16'sha
    && motor.speed >= -16'sha;
  wire short = motor.outTorque < motor.cmdTorque;
  wire [7:0] expCode = faults.overheat ? FC_OVH : faults.overload ? FC_OVL
    : faults.lockRotor ? FC_LOCK : faults.torqueShort ? FC_TQ : FC_NONE;
  // Zeros shown, then cleared
  sequence zerosEnd;
    displayZeros ##1 !displayZeros;
  endsequence
  a_fault_latch: assert property (!restartWr |=> ($past(faults) & ~faults) == 4'h0)
    else $error("fault dropped");
  a_code_order: assert property (faultCode == expCode)
    else $error("wrong fault code");
  a_lock_cause: assert property ($rose(faults.lockRotor) |-> $past(stall))
    else $error("lock fault without stall");
  a_ovl_cause: assert property ($rose(faults.overload) |-> $past(motor.current) > 16'h64)
    else $error("overload without excess");
  a_tq_cause: assert property ($rose(faults.torqueShort) |-> $past(short))
    else $error("shortfall fault without cause");
  a_ovh_cause: assert property ($rose(faults.overheat) |-> $past(motor.overheat))
    else $error("overheat fault without sensor");
  a_load_after_show: assert property (zerosEnd |-> defaultsLoaded)
    else $error("zeros ended without reload");
  a_show_after_hold: assert property ($rose(displayZeros) |-> $past(setKey, 8))
    else $error("zeros without held key");
  a_di_steady: assert property (((diOut ^ $past(diOut))
    & (diOut ^ $past(digitalInputTerminals))) == 8'h0) else $error("input level invented");
endmodule // dpf_properties

bind dpf_top dpf_properties u_props (.clk, .rst, .paddr, .psel, .penable, .pwrite, .pready,
  .motor, .setKey, .digitalInputTerminals, .diOut, .faults, .faultCode, .displayZeros,
  .defaultsLoaded);

// [testbench/dpf_motor_model.sv]
/* Motor model: feedback for the condition the bench picks.
   Assumes cond changes between tests only. */
`timescale 1ns/1ns
module dpf_motor_model
  import dpf_pkg::*;
(
  // Clock and condition
  input  wire logic       clk,
  input  wire logic [2:0] cond,
  // Feedback
  output dpf_pkg::dpf_motor_s motor
);
  // Fast at light load unless a fault case is picked
  localparam dpf_motor_s RUN = '{16'sh3e8, 16'h32, 16'h50, 16'h50, 1'b0};
  initial motor = RUN;
  always @(posedge clk) begin
    case (cond)
      3'h1: motor <= '{16'sh0, 16'hfa, 16'h50, 16'h50, 1'b0};
      3'h2: motor <= '{16'sh3e8, 16'h12c, 16'h50, 16'h50, 1'b0};
      3'h3: motor <= '{16'sh3e8, 16'h32, 16'h50, 16'h14, 1'b0};
      3'h4: motor <= '{16'sh3e8, 16'h32, 16'h50, 16'h50, 1'b1};
      default: motor <= RUN;
    endcase
  end
endmodule // dpf_motor_model

// [testbench/testbench.sv]
/* Bench for dpf_top: APB tasks, register model, motor model.
   Assumes the bound checker; ticks of 10 and 4 clocks. */
`timescale 1ns/1ns
module testbench;
  import dpf_pkg::*;
  // -------
  // Signals
  // -------
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, setKey = 1'b0;
  logic [7:0]  paddr = 8'h00, dIn = 8'h00, diOut, faultCode, v;
  logic [2:0]  encIn = 3'h0, cond = 3'h0, encOut;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, irq, displayZeros, defaultsLoaded, err;
  dpf_motor_s  motor;
  int          mismatches = 0, tests_run = 0, n, t, coef[2] = '{0, 5};
  int          model[int], badD[8] = '{2, 501, 9, 1001, 0, 101, 30001, 0};
  logic [7:0]  badA[8] = '{8'h0, 8'h8, 8'h10, 8'h10, 8'h20, 8'h20, 8'h40, 8'h3c};
  always #50 clk = ~clk;
  dpf_top #(.TICK_CYCLES(10), .DI_TICK_CYCLES(4)) dut (.clk, .rst, .paddr, .psel,
    .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .motor, .setKey, .encIn,
    .digitalInputTerminals(dIn), .encOut, .diOut, .faults(), .faultCode, .displayZeros,
    .defaultsLoaded, .irq);
  dpf_motor_model partner (.clk, .cond, .motor);
  // -----
  // Tasks
  // -----
  task automatic wrap_up(input int hung = 0);
    mismatches += hung;
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Idle cycle after each transfer: psel never has two values at one edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++k < 20);
    if (pready !== 1'b1) wrap_up(1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input int d, input logic bad);
    apb(1'b1, a, 32'(d));
    check(32'(err), 32'(bad));
    if (!bad) model[a] = d;
  endtask
  task automatic rdc(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
    check(rd, 32'(model[a]));
  endtask
  task automatic restart();
    apb(1'b1, OFS_RESTART, 32'h1);
    check(32'(faultCode), 32'h0);
  endtask
  task automatic defaults();
    model = '{0: 0, 8: 100, 12: 1, 16: 50, 20: 0, 24: 0, 28: 1, 32: 10, 44: 0};
    for (int i = 0; i < 8; i++) model[64 + 4 * i] = 2;
  endtask
  // Until code w (<8), zeros (8) or reload pulse (9)
  task automatic waitFor(input int w, lim, output int c);
    for (c = 0; c < lim && !(w < 8 ? faultCode === 8'(w) : w == 8 ? displayZeros
         : defaultsLoaded); c++) @(posedge clk);
    if (c == lim) wrap_up(1);
  endtask
  initial #2000000 wrap_up(1);
  // ---------
  // Scenarios
  // ---------
  initial begin
    void'($urandom(57));
    defaults();
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (model[a]) rdc(8'(a));
    foreach (badA[i]) wr(badA[i], badD[i], 1'b1);
    wr(8'h10, 10, 1'b0);
    cond <= 3'h1;
    waitFor(3, 200, n);
    check(32'(n inside {[85:115]}), 32'h1);
    cond <= 3'h0;
    apb(1'b0, 8'h28, 32'h0);
    check(rd, 32'h2);
    check(32'(faultCode), 32'h3);
    restart();
    wr(8'h0c, 0, 1'b0);
    cond <= 3'h1;
    repeat (150) @(posedge clk);
    check(32'(faultCode), 32'h0);
    cond <= 3'h0;
    wr(8'h20, 1, 1'b0);
    cond <= 3'h3;
    waitFor(4, 30, n);
    check(32'(irq), 32'h0);
    wr(8'h2c, 8, 1'b0);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h1);
    apb(1'b0, 8'h28, 32'h0);
    check(rd, 32'h8);
    repeat (2) @(posedge clk);
    check(32'(irq), 32'h0);
    wr(8'h2c, 0, 1'b0);
    cond <= 3'h0;
    restart();
    // Heat grows 200 a tick at 300 percent; trips above coef*100
    foreach (coef[i]) begin
      wr(8'h08, coef[i], 1'b0);
      cond <= 3'h2;
      t = coef[i] * 100 / 200 + 1;
      waitFor(2, 100, n);
      check(32'(n >= (t - 1) * 10 && n <= t * 10 + 12), 32'h1);
      cond <= 3'h0;
      restart();
    end
    cond <= 3'h4;
    repeat (20) @(posedge clk);
    check(32'(faultCode), 32'h0);
    wr(8'h14, 1, 1'b0);
    waitFor(1, 4, n);
    cond <= 3'h0;
    wr(8'h14, 0, 1'b0);
    restart();
    // Coefficient 30 keeps levels under 10 clocks out
    wr(8'h18, 30, 1'b0);
    encIn <= 3'h7;
    repeat ($urandom_range(8, 1)) @(posedge clk);
    encIn <= 3'h0;
    repeat (15) @(posedge clk);
    check(32'(encOut), 32'h0);
    encIn <= 3'h5;
    repeat (15) @(posedge clk);
    check(32'(encOut), 32'h5);
    wr(8'h18, 0, 1'b0);
    encIn <= 3'h2;
    repeat (2) @(posedge clk);
    check(32'(encOut), 32'h2);
    // One-clock glitch, then a steady random pattern
    wr(8'h40, 0, 1'b0);
    v = 8'($urandom());
    dIn <= v;
    @(posedge clk);
    dIn <= 8'h00;
    repeat (12) @(posedge clk);
    check(32'(diOut), 32'h0);
    dIn <= v;
    repeat (20) @(posedge clk);
    apb(1'b0, 8'h30, 32'h0);
    check(rd, {21'h0, 3'h2, v});
    wr(8'h00, 1, 1'b0);
    setKey <= 1'b1;
    repeat (600) @(posedge clk);
    check(32'(displayZeros), 32'h0);
    setKey <= 1'b0;
    restart();
    setKey <= 1'b1;
    waitFor(8, 700, n);
    check(32'(n >= 500), 32'h1);
    waitFor(9, 5200, n);
    check(32'(n >= 5000), 32'h1);
    setKey <= 1'b0;
    defaults();
    foreach (model[a]) rdc(8'(a));
    wrap_up();
  end
endmodule // testbench
